// ==== core/sxsalu_map.svh ====
// constants of the subtract, xor and swap datapath
// assumes inclusion by bare name from files under core/
`ifndef SXSALU_MAP_SVH
`define SXSALU_MAP_SVH

// operation encodings on op_code
`define SXSALU_OP_NONE      3'h0
`define SXSALU_OP_LIT_SUB   3'h1
`define SXSALU_OP_FILE_SUB  3'h2
`define SXSALU_OP_XOR_LIT   3'h3
`define SXSALU_OP_XOR_FILE  3'h4
`define SXSALU_OP_NIB_SWAP  3'h5

// target select values
`define SXSALU_DEST_ACC     1'b0
`define SXSALU_DEST_FILE    1'b1

// datapath geometry
`define SXSALU_DATA_W       8
`define SXSALU_ADDR_W       7
`define SXSALU_NIB_W        4

// reset values
`define SXSALU_ACC_RST      8'h00
`define SXSALU_ADDR_RST     7'h00
`define SXSALU_FLAG_RST     1'b0

`endif

// ==== core/sxsalu_pkg.sv ====
// types of the subtract, xor and swap datapath
// assumes sxsalu_map.svh is on the include path
`include "sxsalu_map.svh"

package sxsalu_pkg;

  // operation selected by the decoder
  typedef enum logic [2:0] {
    SXSALU_NONE     = `SXSALU_OP_NONE,
    SXSALU_LIT_SUB  = `SXSALU_OP_LIT_SUB,
    SXSALU_FILE_SUB = `SXSALU_OP_FILE_SUB,
    SXSALU_XOR_LIT  = `SXSALU_OP_XOR_LIT,
    SXSALU_XOR_FILE = `SXSALU_OP_XOR_FILE,
    SXSALU_NIB_SWAP = `SXSALU_OP_NIB_SWAP
  } sxsalu_op_t;

endpackage

// ==== core/sxsalu_sub.sv ====
// two's complement subtractor with inverse-borrow outputs
// assumes operands are stable within the cycle; purely combinational
`timescale 1ns/1ps

module sxsalu_sub #(
  parameter int WIDTH = 8,
  parameter int NIB   = 4
) (
  input  wire logic [WIDTH-1:0] minuend,
  input  wire logic [WIDTH-1:0] subtrahend,
  output logic      [WIDTH-1:0] diff,
  output logic                  no_borrow,
  output logic                  no_borrow_low
);

  logic [WIDTH:0] full_sum;
  logic [NIB:0]   low_sum;

  // minuend plus inverted subtrahend plus one; top bit is inverse borrow
  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend}
                  + {{WIDTH{1'b0}}, 1'b1};
  assign low_sum  = {1'b0, minuend[NIB-1:0]} + {1'b0, ~subtrahend[NIB-1:0]}
                  + {{NIB{1'b0}}, 1'b1};

  // outputs of the subtraction
  assign diff          = full_sum[WIDTH-1:0];
  assign no_borrow     = full_sum[WIDTH];
  assign no_borrow_low = low_sum[NIB];

endmodule

// ==== core/sxsalu_core.sv ====
// execution datapath for subtract, xor and nibble swap operations
// assumes the decoder holds op inputs valid for one cycle and the file
// register array presents file_rdata for file_addr in that same cycle
//
// Summary of operation
// - literal_minus_acc puts literal minus accumulator into the acc.
// - file_minus_acc computes file register minus accumulator.
// - file operand results go to the acc on select 0, to the file on 1.
// - xor_literal_acc xors the literal into the acc, touching only zero.
// - xor_file_acc xors acc with file, routes by select, zero only.
// - nibble_exchange swaps the low and high nibbles of the file byte.
// - nibble_exchange routes by select and leaves every flag alone.
`timescale 1ns/1ps
`include "sxsalu_map.svh"

module sxsalu_core #(
  parameter int DATA_W = `SXSALU_DATA_W,
  parameter int ADDR_W = `SXSALU_ADDR_W,
  parameter int NIB_W  = `SXSALU_NIB_W
) (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic                       op_valid,
  input  wire sxsalu_pkg::sxsalu_op_t     op_code,
  input  wire logic [DATA_W-1:0]          literal,
  input  wire logic [ADDR_W-1:0]          file_addr,
  input  wire logic                       dest_sel,
  input  wire logic [DATA_W-1:0]          file_rdata,
  output logic      [DATA_W-1:0]          acc,
  output logic                            carry,
  output logic                            half_borrow_inverse_bit,
  output logic                            zero,
  output logic                            file_we,
  output logic      [ADDR_W-1:0]          file_waddr,
  output logic      [DATA_W-1:0]          file_wdata,
  output logic                            done
);
  import sxsalu_pkg::*;

  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] acc_nxt;
  logic              carry_r;
  logic              carry_nxt;
  logic              hbi_r;
  logic              hbi_nxt;
  logic              zero_r;
  logic              zero_nxt;
  logic              we_r;
  logic              we_nxt;
  logic [ADDR_W-1:0] waddr_r;
  logic [ADDR_W-1:0] waddr_nxt;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wdata_nxt;
  logic              done_r;
  logic              done_nxt;

  logic [DATA_W-1:0] minuend;
  logic [DATA_W-1:0] diff;
  logic              no_borrow;
  logic              no_borrow_low;
  logic [DATA_W-1:0] result;
  logic              legal;
  logic              to_file;
  logic              is_sub;
  logic              is_xor;

  // minuend is the literal for the literal form, else the file byte
  assign minuend = (op_code == SXSALU_LIT_SUB) ? literal : file_rdata;

  // shared subtractor for both subtract forms
  sxsalu_sub #(
    .WIDTH (DATA_W),
    .NIB   (NIB_W)
  ) u_sub (
    .minuend       (minuend),
    .subtrahend    (acc_r),
    .diff          (diff),
    .no_borrow     (no_borrow),
    .no_borrow_low (no_borrow_low)
  );

  // operation decode, result select and destination
  always_comb begin
    result  = diff;
    legal   = 1'b0;
    to_file = 1'b0;
    is_sub  = 1'b0;
    is_xor  = 1'b0;
    unique case (op_code)
      SXSALU_LIT_SUB: begin
        result = diff;
        legal  = 1'b1;
        is_sub = 1'b1;
      end
      SXSALU_FILE_SUB: begin
        result  = diff;
        legal   = 1'b1;
        is_sub  = 1'b1;
        to_file = (dest_sel == `SXSALU_DEST_FILE);
      end
      SXSALU_XOR_LIT: begin
        result = acc_r ^ literal;
        legal  = 1'b1;
        is_xor = 1'b1;
      end
      SXSALU_XOR_FILE: begin
        result  = acc_r ^ file_rdata;
        legal   = 1'b1;
        is_xor  = 1'b1;
        to_file = (dest_sel == `SXSALU_DEST_FILE);
      end
      SXSALU_NIB_SWAP: begin
        result  = {file_rdata[NIB_W-1:0],
                   file_rdata[DATA_W-1:NIB_W]};
        legal   = 1'b1;
        to_file = (dest_sel == `SXSALU_DEST_FILE);
      end
      default: begin
        legal = 1'b0; // unused codes are ignored
      end
    endcase
  end

  // next state of accumulator, flags and file write port
  always_comb begin
    acc_nxt   = acc_r;
    carry_nxt = carry_r;
    hbi_nxt   = hbi_r;
    zero_nxt  = zero_r;
    we_nxt    = 1'b0;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    done_nxt  = 1'b0;
    if (op_valid && legal) begin
      done_nxt = 1'b1;
      if (to_file) begin
        we_nxt    = 1'b1;
        waddr_nxt = file_addr;
        wdata_nxt = result;
      end else begin
        acc_nxt = result;
      end
      if (is_sub) begin
        carry_nxt = no_borrow;
        hbi_nxt   = no_borrow_low;
      end
      if (is_sub || is_xor) begin
        zero_nxt = (result == {DATA_W{1'b0}});
      end
    end
  end

  // state registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r   <= `SXSALU_ACC_RST;
      carry_r <= `SXSALU_FLAG_RST;
      hbi_r   <= `SXSALU_FLAG_RST;
      zero_r  <= `SXSALU_FLAG_RST;
      we_r    <= 1'b0;
      waddr_r <= `SXSALU_ADDR_RST;
      wdata_r <= `SXSALU_ACC_RST;
      done_r  <= 1'b0;
    end else begin
      acc_r   <= acc_nxt;
      carry_r <= carry_nxt;
      hbi_r   <= hbi_nxt;
      zero_r  <= zero_nxt;
      we_r    <= we_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      done_r  <= done_nxt;
    end
  end

  // outputs straight from registers
  assign acc                     = acc_r;
  assign carry                   = carry_r;
  assign half_borrow_inverse_bit = hbi_r;
  assign zero                    = zero_r;
  assign file_we                 = we_r;
  assign file_waddr              = waddr_r;
  assign file_wdata              = wdata_r;
  assign done                    = done_r;

  // helpers for checks on the low nibbles
  logic [NIB_W-1:0] acc_low;
  logic [NIB_W-1:0] min_low;
  assign acc_low = acc_r[NIB_W-1:0];
  assign min_low = minuend[NIB_W-1:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // issue sequences per operation
  sequence s_lit_sub;
    op_valid && op_code == SXSALU_LIT_SUB;
  endsequence
  sequence s_file_sub;
    op_valid && op_code == SXSALU_FILE_SUB;
  endsequence
  sequence s_xor_lit;
    op_valid && op_code == SXSALU_XOR_LIT;
  endsequence
  sequence s_xor_file;
    op_valid && op_code == SXSALU_XOR_FILE;
  endsequence
  sequence s_swap;
    op_valid && op_code == SXSALU_NIB_SWAP;
  endsequence
  sequence s_to_file;
    dest_sel == `SXSALU_DEST_FILE;
  endsequence

  a_lit_sub_acc: assert property (
    s_lit_sub |=> acc_r == $past(literal) - $past(acc_r) && !we_r)
    else $error("literal minus acc result wrong");

  a_file_sub_val: assert property (
    s_file_sub ##0 s_to_file |=>
      we_r && wdata_r == $past(file_rdata) - $past(acc_r))
    else $error("file minus acc result wrong");

  a_dest_route_acc: assert property (
    (s_file_sub or s_xor_file or s_swap) ##0 !dest_sel |=>
      !we_r && done_r)
    else $error("acc target wrote the file");

  a_dest_route_file: assert property (
    (s_file_sub or s_xor_file) ##0 s_to_file |=>
      acc_r == $past(acc_r) && waddr_r == $past(file_addr))
    else $error("file target disturbed acc or address");

  a_xor_lit_flags: assert property (
    s_xor_lit |=> acc_r == ($past(acc_r) ^ $past(literal)) &&
      $stable(carry_r) && $stable(hbi_r) && zero_r == (acc_r == 8'h00))
    else $error("xor literal result or flags wrong");

  a_xor_file_val: assert property (
    s_xor_file ##0 s_to_file |=>
      wdata_r == ($past(acc_r) ^ $past(file_rdata)) &&
      $stable(carry_r) && zero_r == (wdata_r == 8'h00))
    else $error("xor file result or flags wrong");

  a_swap_nibbles: assert property (
    s_swap ##0 !dest_sel |=>
      acc_r[3:0] == $past(file_rdata[7:4]) &&
      acc_r[7:4] == $past(file_rdata[3:0]))
    else $error("nibble swap wrong");

  a_swap_flags_hold: assert property (
    s_swap |=> $stable(carry_r) && $stable(hbi_r) && $stable(zero_r))
    else $error("nibble swap changed a flag");

  a_sub_carry_flag: assert property (
    s_lit_sub or s_file_sub |=>
      carry_r == ($past(acc_r) <= $past(minuend)) &&
      hbi_r == ($past(acc_low) <= $past(min_low)))
    else $error("subtract carry or half flag wrong");

  a_sub_zero_flag: assert property (
    s_lit_sub |=> zero_r == (acc_r == 8'h00))
    else $error("subtract zero flag wrong");

  a_idle_hold: assert property (
    !op_valid |=> !we_r && !done_r && $stable(acc_r) && $stable(zero_r))
    else $error("state changed with no operation");

endmodule

// ==== testbench/sxsalu_regfile.sv ====
// file register model facing the subtract, xor and swap datapath
// assumes one clock; a write in flight is forwarded to a same-address read
`timescale 1ns/1ps

module sxsalu_regfile (
  input  wire logic       clk,
  input  wire logic [6:0] file_addr,
  output logic      [7:0] file_rdata,
  input  wire logic       file_we,
  input  wire logic [6:0] file_waddr,
  input  wire logic [7:0] file_wdata
);
  logic [7:0] mem [128];

  // seed pattern, mirrored by the bench model
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 29) ^ 8'h5a;
    end
  end

  // write back of file-targeted results
  always @(posedge clk) begin
    if (file_we) begin
      mem[file_waddr] <= file_wdata;
    end
  end

  // read port; forwarding avoids a stale operand on back to back ops
  assign file_rdata = (file_we && file_waddr == file_addr) ?
                      file_wdata : mem[file_addr];
endmodule

// ==== testbench/test_subtract_xor_swap_alu.sv ====
// self-checking bench of the subtract, xor and swap datapath
// assumes sxsalu_pkg and the regfile model are compiled first
`timescale 1ns/1ps

module test_subtract_xor_swap_alu;
  import sxsalu_pkg::*;
  logic       clk, arst_n, op_valid, dest_sel, carry, half, zero;
  logic       file_we, done;
  sxsalu_op_t op_code;
  logic [7:0] literal, file_rdata, acc, file_wdata;
  logic [6:0] file_addr, file_waddr;
  int         miscompares = 0;
  int         compares = 0;
  int         m_acc, m_c, m_h, m_z, m_we, m_wa, m_wd, m_dn;
  int         mem [128];
  int         opc, k, a, d, v;

  sxsalu_core uut (.clk(clk), .arst_n(arst_n), .op_valid(op_valid),
    .op_code(op_code), .literal(literal), .file_addr(file_addr),
    .dest_sel(dest_sel), .file_rdata(file_rdata), .acc(acc),
    .carry(carry), .half_borrow_inverse_bit(half), .zero(zero),
    .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .done(done));

  sxsalu_regfile rf (.clk(clk), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata));

  // byte result comparison
  task automatic chk_v(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // flag and strobe comparison
  task automatic chk_f(logic got, logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // reference model of one request
  task automatic step();
    int f;
    int r;
    f = mem[a];
    r = 0;
    m_dn = 0;
    m_we = 0;
    if (v != 0 && opc >= 1 && opc <= 5) begin
      m_dn = 1;
      case (opc)
        1, 2: begin
          r = (opc == 1) ? k : f;
          m_c = int'(m_acc <= r);
          m_h = int'((m_acc & 15) <= (r & 15));
          r = (r - m_acc) & 255;
          m_z = int'(r == 0);
        end
        3, 4: begin
          r = m_acc ^ ((opc == 3) ? k : f);
          m_z = int'(r == 0);
        end
        default: r = ((f & 15) << 4) | (f >> 4);
      endcase
      if (opc != 1 && opc != 3 && d == 1) begin
        mem[a] = r;
        m_we = 1;
        m_wa = a;
        m_wd = r;
      end else begin
        m_acc = r;
      end
    end
  endtask

  // compare every output with the model
  task automatic check_all();
    chk_v(acc, 8'(m_acc));
    chk_f(carry, 1'(m_c));
    chk_f(half, 1'(m_h));
    chk_f(zero, 1'(m_z));
    chk_f(done, 1'(m_dn));
    chk_f(file_we, 1'(m_we));
    chk_v({1'b0, file_waddr}, 8'(m_wa));
    chk_v(file_wdata, 8'(m_wd));
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // watchdog, well past the expected run length
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end

  // reset, directed borrow cases, then random back to back requests
  initial begin
    arst_n = 1'b0;
    op_valid = 1'b0;
    op_code = SXSALU_NONE;
    literal = 8'h00;
    file_addr = 7'h00;
    dest_sel = 1'b0;
    {m_acc, m_c, m_h, m_z, m_we, m_wa, m_wd, m_dn} = '0;
    for (int i = 0; i < 128; i++) begin
      mem[i] = ((i * 29) & 255) ^ 90;
    end
    k = $urandom(54898);
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check_all();
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      v = int'(($urandom % 4) != 0);
      opc = $urandom % 8;
      k = $urandom % 256;
      a = (i % 2 != 0) ? $urandom % 128 : 124 + $urandom % 4;
      d = $urandom % 2;
      if (i < 4) begin
        v = 1;
        opc = 1;
        k = int'(i == 2);
      end
      op_valid <= v[0];
      op_code <= sxsalu_op_t'(3'(opc));
      literal <= 8'(k);
      file_addr <= 7'(a);
      dest_sel <= d[0];
      @(negedge clk);
      check_all();
      step();
    end
    @(posedge clk);
    op_valid <= 1'b0;
    @(negedge clk);
    check_all();
    end_sim();
  end
endmodule
